// ===== core/cta_core.sv
/*
  command handling of a channel to channel adapter: side 0 is channel x,
  side 1 is channel y. pairs read and write through a one-byte command
  buffer and moves data through a fifo.
  assumes each channel holds cmd_valid until it sees cmd_ready, and that
  reset request inputs are single-cycle pulses.
*/
`default_nettype none
`include "cta_defs.svh"
// Operation
// - sense adapter first returns zero status
// - system reset opposite: sense bit 1 only
// - halt or selective reset: bits 1 and 7
// - opposite ready: sense byte all zero
// - after sense byte send channel/device end
// - only moving commands from causer clear not-ready
// - read backward handled as read, except that only read can be a load read
// - read at idle: zero status, buffered, attention
// - transfer after pairing; both get ending status
// - read meeting held write starts transfer
// - read answering write: zero status, transfer
// - end-of-file write ends other side's read
// - held eof in initial, else ending status
// - read termination also clears eof write
// - write at idle: zero status, buffered, attention
// - write meeting held read starts transfer
// - write answering read: zero status, transfer
// - load read ends earlier write with check
// - transfer stops at smaller byte count
// - real control at idle buffered, attention
// - reset disconnects, clears, makes side not ready
module cta_core
  import cta_pkg::*;
(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            nrst,
  // command requests
  input  wire logic [1:0]      cmd_valid,
  input  wire logic [1:0][7:0] cmd_byte,
  input  wire logic [1:0][15:0] cmd_count,
  input  wire logic [1:0]      load_active,
  output var  logic [1:0]      cmd_ready,
  // status and sense answers
  output var  logic [1:0]      status_valid,
  output var  logic [1:0][7:0] status_byte,
  output var  logic [1:0]      sense_valid,
  output var  logic [1:0][7:0] sense_byte,
  output var  logic [1:0]      attention,
  output var  logic [1:0]      not_ready,
  // reset events from each channel
  input  wire logic [1:0]      sys_reset_req,
  input  wire logic [1:0]      sel_reset_req,
  input  wire logic [1:0]      halt_req,
  // data from the writing channel
  input  wire logic [1:0]      wr_valid,
  input  wire logic [1:0][7:0] wr_data,
  output logic      [1:0]      wr_ready,
  // data to the reading channel
  output logic      [1:0]      rd_valid,
  output logic      [1:0][7:0] rd_data,
  input  wire logic [1:0]      rd_ready
);
  // ----------------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------------
  function automatic cta_cmd_e cta_decode(input cta_byte_t b);
    cta_cmd_e c;
    c = CMD_BAD;
    if (b == `CTA_OP_WRITE)
      c = CMD_WRITE;
    else if (b == `CTA_OP_WEOF)
      c = CMD_WEOF;
    else if (b == `CTA_OP_SENSE_ADP)
      c = CMD_SENSE_ADP;
    else if (b == `CTA_OP_SENSE_CMD)
      c = CMD_SENSE_CMD;
    else if (b == `CTA_OP_READ || b == `CTA_OP_READ_BACK)
      c = CMD_READ;
    else if ((b & `CTA_OP_CTRL_MASK) == `CTA_OP_CTRL_VAL)
      c = ((b & `CTA_OP_CTRL_ACT) == 8'h00) ? CMD_NOOP : CMD_CTRL;
    return c;
  endfunction

  function automatic cta_byte_t cta_sense_of(input logic nr, input logic halt);
    cta_byte_t s;
    s = 8'h00;
    if (nr)
      s = halt ? (`CTA_SNS_INTV | `CTA_SNS_HALT) : `CTA_SNS_INTV;
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  cta_state_e state_q;
  cta_state_e state_d;
  logic       turn_q;
  logic       buf_v_q;
  logic       buf_side_q;
  cta_byte_t  buf_byte_q;
  cta_cnt_t   buf_cnt_q;
  logic [1:0] weof_q;
  logic [1:0] nr_q;
  logic [1:0] halt_q;
  logic       sns_side_q;
  logic       sns_cmd_q;
  logic       rd_side_q;
  cta_cnt_t   len_q;
  cta_cnt_t   in_cnt_q;
  cta_cnt_t   out_cnt_q;

  logic       a;
  logic       acc;
  cta_cmd_e   cmd;
  cta_cmd_e   bcls;
  logic       o_pend_w;
  logic       o_pend_r;
  logic       moves;
  logic       nr_a_eff;
  logic [1:0] st_give;
  logic [1:0][7:0] st_val;
  logic       buf_store;
  logic       buf_clr;
  logic       weof_set;
  logic       weof_clr_o;
  logic       nr_clr_a;
  logic       xfer_go;
  logic       sns_go;
  logic       sns_is_cmd;
  logic [1:0] rst_ev;
  logic       in_xfer;
  logic       push;
  logic       pop;

  cta_fifo_if #(.W(`CTA_BYTE_W)) fq ();

  assign rst_ev = sys_reset_req | sel_reset_req | halt_req;

  // ----------------------------------------------------------------------
  // command decision
  // ----------------------------------------------------------------------
  always_comb
  begin
    a          = cmd_ready[1];
    acc        = |(cmd_valid & cmd_ready);
    cmd        = cta_decode(cmd_byte[a]);
    bcls       = cta_decode(buf_byte_q);
    o_pend_w   = buf_v_q & (buf_side_q != a) & (bcls == CMD_WRITE);
    o_pend_r   = buf_v_q & (buf_side_q != a) & (bcls == CMD_READ);
    moves      = (cmd == CMD_READ) | (cmd == CMD_WRITE) | (cmd == CMD_WEOF) | (cmd == CMD_NOOP) | (cmd == CMD_CTRL);
    nr_a_eff   = nr_q[a] & ~moves;
    st_give    = 2'b00;
    st_val     = '0;
    buf_store  = 1'b0;
    buf_clr    = 1'b0;
    weof_set   = 1'b0;
    weof_clr_o = 1'b0;
    nr_clr_a   = 1'b0;
    xfer_go    = 1'b0;
    sns_go     = 1'b0;
    sns_is_cmd = 1'b0;
    state_d    = state_q;
    unique case (state_q)
      ST_IDLE, ST_XFER:
      begin
        if (state_q == ST_XFER && out_cnt_q == len_q)
          state_d = ST_XFER_END;
        if (acc)
        begin
          st_give[a] = 1'b1;
          nr_clr_a   = nr_q[a] & moves;
          if (cmd == CMD_BAD || ((nr_q[~a] | nr_a_eff) && cmd != CMD_SENSE_ADP))
            st_val[a] = `CTA_ST_UC;
          else if (state_q == ST_XFER)
            st_val[a] = `CTA_ST_BUSY;
          else
          begin
            // a held eof write from the far side is cleared by any command here; a read clears it in its own branch
            if (weof_q[~a] && cmd != CMD_READ)
              weof_clr_o = 1'b1;
            unique case (cmd)
              CMD_SENSE_ADP, CMD_SENSE_CMD:
              begin
                st_val[a]  = `CTA_ST_ZERO;
                sns_go     = 1'b1;
                sns_is_cmd = (cmd == CMD_SENSE_CMD);
              end
              CMD_NOOP:
                st_val[a] = `CTA_ST_CE | `CTA_ST_DE;
              CMD_WEOF:
              begin
                st_val[a] = `CTA_ST_CE | `CTA_ST_DE;
                if (o_pend_r)
                begin
                  st_give[~a] = 1'b1;
                  st_val[~a]  = `CTA_ST_CE | `CTA_ST_DE | `CTA_ST_UX;
                  buf_clr     = 1'b1;
                end
                else
                  weof_set = 1'b1;
              end
              CMD_READ:
              begin
                if (weof_q[~a])
                begin
                  st_val[a]  = `CTA_ST_CE | `CTA_ST_DE | `CTA_ST_UX;
                  weof_clr_o = 1'b1;
                end
                else if (o_pend_w && load_active[a] && cmd_byte[a] == `CTA_OP_READ)
                begin
                  st_val[a]   = `CTA_ST_ZERO;
                  st_give[~a] = 1'b1;
                  st_val[~a]  = `CTA_ST_CE | `CTA_ST_DE | `CTA_ST_UC;
                  buf_clr     = 1'b1;
                  buf_store   = 1'b1;
                end
                else if (o_pend_w)
                begin
                  st_val[a] = `CTA_ST_ZERO;
                  xfer_go   = 1'b1;
                end
                else if (!buf_v_q)
                begin
                  st_val[a] = `CTA_ST_ZERO;
                  buf_store = 1'b1;
                end
                else
                  st_val[a] = `CTA_ST_BUSY;
              end
              CMD_WRITE:
              begin
                if (o_pend_r)
                begin
                  st_val[a] = `CTA_ST_ZERO;
                  xfer_go   = 1'b1;
                end
                else if (!buf_v_q)
                begin
                  st_val[a] = `CTA_ST_ZERO;
                  buf_store = 1'b1;
                end
                else
                  st_val[a] = `CTA_ST_BUSY;
              end
              CMD_CTRL:
              begin
                if (!buf_v_q)
                begin
                  st_val[a] = `CTA_ST_CE;
                  buf_store = 1'b1;
                end
                else
                  st_val[a] = `CTA_ST_BUSY;
              end
              default:
                st_val[a] = `CTA_ST_UC;
            endcase
            if (xfer_go)
            begin
              buf_clr = 1'b1;
              state_d = ST_XFER;
            end
            if (sns_go)
              state_d = ST_SNS_DATA;
          end
        end
      end
      ST_SNS_DATA:
        state_d = ST_SNS_END;
      ST_SNS_END:
      begin
        st_give[sns_side_q] = 1'b1;
        st_val[sns_side_q]  = `CTA_ST_CE | `CTA_ST_DE;
        if (sns_cmd_q && buf_v_q && buf_side_q != sns_side_q)
        begin
          buf_clr = 1'b1;
          if (bcls == CMD_CTRL)
          begin
            st_give[buf_side_q] = 1'b1;
            st_val[buf_side_q]  = `CTA_ST_DE;
          end
        end
        state_d = ST_IDLE;
      end
      ST_XFER_END:
      begin
        st_give = 2'b11;
        st_val  = {2{`CTA_ST_CE | `CTA_ST_DE}};
        state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
    if (|rst_ev)
      state_d = ST_IDLE;
  end

  // ----------------------------------------------------------------------
  // sequencing and command acceptance
  // ----------------------------------------------------------------------
  // sides take turns so that only one command is taken per cycle
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q   <= ST_IDLE;
      turn_q    <= 1'b0;
      cmd_ready <= 2'b00;
    end
    else
    begin
      state_q      <= state_d;
      turn_q       <= ~turn_q;
      cmd_ready[0] <= (state_d == ST_IDLE || state_d == ST_XFER) & turn_q;
      cmd_ready[1] <= (state_d == ST_IDLE || state_d == ST_XFER) & ~turn_q;
    end
  end

  // ----------------------------------------------------------------------
  // command buffer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      buf_v_q    <= 1'b0;
      buf_side_q <= 1'b0;
      buf_byte_q <= 8'h00;
      buf_cnt_q  <= 16'h0000;
    end
    else if (|rst_ev)
      buf_v_q <= 1'b0;
    else if (buf_store)
    begin
      buf_v_q    <= 1'b1;
      buf_side_q <= a;
      buf_byte_q <= cmd_byte[a];
      buf_cnt_q  <= cmd_count[a];
    end
    else if (buf_clr)
      buf_v_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // not-ready and end-of-file latches
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      weof_q <= 2'b00;
      nr_q   <= 2'b00;
      halt_q <= 2'b00;
    end
    else if (|rst_ev)
    begin
      weof_q <= 2'b00;
      nr_q   <= nr_q | rst_ev;
      halt_q <= (halt_q & ~rst_ev) | sel_reset_req | halt_req;
    end
    else
    begin
      // separate bits: an eof write must also drop the far side's held eof
      if (weof_set)
        weof_q[a] <= 1'b1;
      if (weof_clr_o)
        weof_q[~a] <= 1'b0;
      if (nr_clr_a)
        nr_q[a] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // sense byte
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sns_side_q  <= 1'b0;
      sns_cmd_q   <= 1'b0;
      sense_valid <= 2'b00;
      sense_byte  <= '0;
    end
    else
    begin
      if (sns_go)
      begin
        sns_side_q <= a;
        sns_cmd_q  <= sns_is_cmd;
      end
      sense_valid <= 2'b00;
      if (state_q == ST_SNS_DATA)
      begin
        sense_valid[sns_side_q] <= 1'b1;
        if (sns_cmd_q)
          sense_byte[sns_side_q] <= buf_v_q ? buf_byte_q : 8'h00;
        else
          sense_byte[sns_side_q] <= cta_sense_of(nr_q[~sns_side_q], halt_q[~sns_side_q]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // data transfer
  // ----------------------------------------------------------------------
  assign in_xfer       = (state_q == ST_XFER);
  assign fq.push_valid = in_xfer & wr_valid[~rd_side_q] & (in_cnt_q != len_q);
  assign fq.push_data  = wr_data[~rd_side_q];
  assign fq.pop_ready  = in_xfer & rd_ready[rd_side_q];
  assign fq.flush      = xfer_go | (|rst_ev);
  assign push          = fq.push_valid & fq.push_ready;
  assign pop           = fq.pop_valid & fq.pop_ready;

  for (genvar s = 0; s < 2; s++)
  begin : g_side
    assign wr_ready[s] = in_xfer & (rd_side_q != s) & fq.push_ready & (in_cnt_q != len_q);
    assign rd_valid[s] = in_xfer & (rd_side_q == s) & fq.pop_valid;
    assign rd_data[s]  = fq.pop_data;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_side_q <= 1'b0;
      len_q     <= 16'h0000;
      in_cnt_q  <= 16'h0000;
      out_cnt_q <= 16'h0000;
    end
    else if (xfer_go)
    begin
      rd_side_q <= (cmd == CMD_READ) ? a : ~a;
      len_q     <= (buf_cnt_q < cmd_count[a]) ? buf_cnt_q : cmd_count[a];
      in_cnt_q  <= 16'h0000;
      out_cnt_q <= 16'h0000;
    end
    else
    begin
      in_cnt_q  <= in_cnt_q + 16'(push);
      out_cnt_q <= out_cnt_q + 16'(pop);
    end
  end

  cta_fifo #(.W(`CTA_BYTE_W), .D(`CTA_FIFO_DEPTH)) u_fifo (
    .clk  (sys_clk),
    .nrst (nrst),
    .f    (fq)
  );

  // ----------------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_valid <= 2'b00;
      status_byte  <= '0;
      attention    <= 2'b00;
      not_ready    <= 2'b00;
    end
    else
    begin
      status_valid <= st_give;
      for (int s = 0; s < 2; s++)
      begin
        if (st_give[s])
          status_byte[s] <= st_val[s];
        attention[s] <= buf_v_q & (buf_side_q != s);
      end
      not_ready <= nr_q;
    end
  end
endmodule
`default_nettype wire

// ===== include/cta_defs.svh
/*
  constants of the channel to channel adapter: command codes, status and
  sense bit masks, buffer sizes. assumes nothing of its surroundings.
*/
`ifndef CTA_DEFS_SVH
`define CTA_DEFS_SVH
// ----------------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------------
`define CTA_OP_WRITE      8'h01
`define CTA_OP_READ       8'h02
`define CTA_OP_SENSE_CMD  8'h04
`define CTA_OP_READ_BACK  8'h0C
`define CTA_OP_SENSE_ADP  8'h14
`define CTA_OP_WEOF       8'h1D
`define CTA_OP_CTRL_MASK  8'h03
`define CTA_OP_CTRL_VAL   8'h03
`define CTA_OP_READ_MASK  8'h03
`define CTA_OP_CTRL_ACT   8'h04
// ----------------------------------------------------------------------
// status and sense bits, bit 0 is the msb
// ----------------------------------------------------------------------
`define CTA_ST_ZERO       8'h00
`define CTA_ST_BUSY       8'h10
`define CTA_ST_CE         8'h08
`define CTA_ST_DE         8'h04
`define CTA_ST_UC         8'h02
`define CTA_ST_UX         8'h01
`define CTA_SNS_INTV      8'h40
`define CTA_SNS_HALT      8'h01
// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define CTA_FIFO_DEPTH    8
`define CTA_BYTE_W        8
`endif

// ===== include/cta_pkg.sv
/*
  types of the channel to channel adapter.
  assumes cta_defs.svh on the include path.
*/
`default_nettype none
package cta_pkg;
  typedef logic [7:0]  cta_byte_t;
  typedef logic [15:0] cta_cnt_t;
  typedef enum logic [2:0] {
    CMD_READ, CMD_WRITE, CMD_WEOF, CMD_NOOP, CMD_CTRL, CMD_SENSE_ADP, CMD_SENSE_CMD, CMD_BAD
  } cta_cmd_e;
  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_SNS_DATA = 5'b00010,
    ST_SNS_END  = 5'b00100,
    ST_XFER     = 5'b01000,
    ST_XFER_END = 5'b10000
  } cta_state_e;
endpackage
`default_nettype wire

// ===== include/cta_fifo_if.sv
/*
  data path carrier between the adapter core and its fifo.
  assumes both ends run on the same clock.
*/
`default_nettype none
interface cta_fifo_if #(parameter int W = 8);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  logic         flush;
  modport src  (output push_valid, push_data, pop_ready, flush,
                input  push_ready, pop_valid, pop_data);
  modport fifo (input  push_valid, push_data, pop_ready, flush,
                output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// ===== core/cta_mem.sv
/*
  small storage array with a registered read port.
  assumes one clock; the array itself has no reset.
*/
`default_nettype none
module cta_mem #(
  parameter int W  = 8,
  parameter int D  = 8,
  parameter int AW = 3
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read port
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output var  logic [W-1:0]  rdata_q
);
  logic [W-1:0] mem_q [D];

  always_ff @(posedge clk)
  begin
    if (we)
      mem_q[waddr] <= wdata;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= '0;
    else if (re)
      rdata_q <= mem_q[raddr];
  end
endmodule
`default_nettype wire

// ===== core/cta_fifo.sv
/*
  fifo between writer channel and reader channel.
  assumes flush is only raised between transfers or on a reset event.
*/
`default_nettype none
module cta_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // fifo ports
  cta_fifo_if.fifo  f
);
  localparam int         AW   = $clog2(D);
  localparam logic [AW:0] FULL = D[AW:0];

  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          out_v_q;
  logic          push;
  logic          issue;

  // the output register adds one word of slack above the array
  assign f.push_ready = (cnt_q != FULL);
  assign push         = f.push_valid & f.push_ready;
  assign issue        = (cnt_q != '0) & (~out_v_q | f.pop_ready);
  assign f.pop_valid  = out_v_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      out_v_q <= 1'b0;
    end
    else if (f.flush)
    begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      out_v_q <= 1'b0;
    end
    else
    begin
      wp_q    <= wp_q + AW'(push);
      rp_q    <= rp_q + AW'(issue);
      cnt_q   <= cnt_q + (AW+1)'(push) - (AW+1)'(issue);
      out_v_q <= issue | (out_v_q & ~f.pop_ready);
    end
  end

  cta_mem #(.W(W), .D(D), .AW(AW)) u_mem (
    .clk     (clk),
    .nrst    (nrst),
    .we      (push),
    .waddr   (wp_q),
    .wdata   (f.push_data),
    .re      (issue),
    .raddr   (rp_q),
    .rdata_q (f.pop_data)
  );
endmodule
`default_nettype wire

// ===== tb/cta_chan_model.sv
/*
  one channel's data pins: counted bytes out, bytes taken in.
  assumes the adapter gates both sides.
*/
`default_nettype none
module cta_chan_model #(
  parameter logic [7:0] BASE = 8'h10
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // pacing
  input  wire logic       slow,
  // bytes toward the adapter
  input  wire logic       wr_ready,
  output logic            wr_valid,
  output logic [7:0]      wr_data,
  // bytes from the adapter
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output logic            rd_ready,
  // tallies
  output int              rx_cnt,
  output int              tx_cnt,
  output logic [7:0]      rx_last
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tick_q;
  // always offering; the adapter gates
  assign wr_valid = nrst;
  assign wr_data  = BASE + tx_cnt[7:0];
  assign rd_ready = nrst & (~slow | tick_q);
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tick_q  <= 1'b0;
      rx_cnt  <= 0;
      tx_cnt  <= 0;
      rx_last <= 8'h00;
    end
    else
    begin
      tick_q <= ~tick_q;
      if (wr_valid && wr_ready)
        tx_cnt <= tx_cnt + 1;
      if (rd_valid && rd_ready)
      begin
        rx_cnt  <= rx_cnt + 1;
        rx_last <= rd_data;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/cta_core_checker.sv
/*
  port-level checks of the adapter core.
  assumes cta_defs.svh on the include path.
*/
`default_nettype none
`include "cta_defs.svh"
module cta_core_checker (
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            nrst,
  // commands
  input wire logic [1:0]      cmd_valid,
  input wire logic [1:0]      cmd_ready,
  input wire logic [1:0][7:0] cmd_byte,
  // answers
  input wire logic [1:0]      status_valid,
  input wire logic [1:0][7:0] status_byte,
  input wire logic [1:0]      sense_valid,
  input wire logic [1:0][7:0] sense_byte,
  input wire logic [1:0]      attention,
  input wire logic [1:0]      not_ready,
  // reset events
  input wire logic [1:0]      sys_reset_req,
  input wire logic [1:0]      sel_reset_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [1:0] tk;
  assign tk = cmd_valid & cmd_ready;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sense_init_a: assert property (tk[0] && cmd_byte[0] == `CTA_OP_SENSE_ADP |=>
    status_valid[0] && status_byte[0] == `CTA_ST_ZERO) else $error("sense initial");
  sense_end_a: assert property (tk[0] && cmd_byte[0] == `CTA_OP_SENSE_ADP |-> ##2 sense_valid[0]
    ##1 status_valid[0] && status_byte[0] == 8'h0C) else $error("sense ending");
  sense_zero_a: assert property (tk[1] && cmd_byte[1] == `CTA_OP_SENSE_ADP && !not_ready[0] |->
    ##2 sense_valid[1] && sense_byte[1] == 8'h00) else $error("sense byte");
  nr_keep_a: assert property (tk[1] && cmd_byte[1] == `CTA_OP_SENSE_ADP && not_ready[0] |=>
    not_ready[0] [*3]) else $error("not ready lost");
  refuse_a: assert property (tk[1] && cmd_byte[1] == `CTA_OP_READ && not_ready[0] |=>
    status_valid[1] && status_byte[1] == `CTA_ST_UC) else $error("no unit check");
  mov_init_a: assert property (tk[0] && cmd_byte[0] inside {`CTA_OP_READ, `CTA_OP_WRITE} |=>
    status_valid[0]) else $error("no initial status");
  reset_nr_a: assert property (sel_reset_req[0] |-> ##[1:3] not_ready[0])
    else $error("reset left side ready");
  reset_att_a: assert property (sel_reset_req[0] |-> ##[1:2] attention == 2'b00)
    else $error("reset left buffer");
  sysres_nr_a: assert property (sys_reset_req[1] |-> ##[1:3] not_ready[1])
    else $error("system reset left side ready");
endmodule
bind cta_core cta_core_checker chk_i (.*);
`default_nettype wire

// ===== tb/testbench.sv
/*
  command sequences on both channels of the adapter core with checks.
  assumes cta_pkg, cta_defs.svh and the core sources compiled before.
*/
`default_nettype none
`include "cta_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CEDE = `CTA_ST_CE | `CTA_ST_DE;
  logic sys_clk, nrst, slow;
  logic [1:0] cmd_valid, load_active, sys_reset_req, sel_reset_req, halt_req;
  logic [1:0][7:0] cmd_byte;
  logic [1:0][15:0] cmd_count;
  wire logic [1:0] cmd_ready, status_valid, sense_valid, attention, not_ready;
  wire logic [1:0] wr_valid, wr_ready, rd_valid, rd_ready;
  wire logic [1:0][7:0] status_byte, sense_byte, wr_data, rd_data;
  int rxc [2];
  int txc [2];
  logic [7:0] rxl [2];
  int fail_count, checks;
  cta_core DUT (.*);
  for (genvar g = 0; g < 2; g++)
  begin : ch
    cta_chan_model #(.BASE(g ? 8'h80 : 8'h10)) m (.sys_clk(sys_clk), .nrst(nrst), .slow(slow && g == 1),
      .wr_ready(wr_ready[g]), .wr_valid(wr_valid[g]), .wr_data(wr_data[g]), .rd_valid(rd_valid[g]),
      .rd_data(rd_data[g]), .rd_ready(rd_ready[g]), .rx_cnt(rxc[g]), .tx_cnt(txc[g]), .rx_last(rxl[g]));
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ready seen now is for the coming edge; valid drops 2 ns after the taking edge
  task automatic cmd(input int s, input logic [7:0] b, input logic [15:0] n, input logic [7:0] exp);
    int i;
    i = 0;
    cmd_byte[s] = b;
    cmd_count[s] = n;
    cmd_valid[s] = 1'b1;
    while (cmd_ready[s] !== 1'b1 && ++i < 50) #50;
    #50 cmd_valid[s] = 1'b0;
    chk(status_valid[s], 1'b1);
    chk(status_byte[s], exp);
  endtask
  task automatic sense(input int s, input logic [7:0] exp);
    cmd(s, `CTA_OP_SENSE_ADP, 1, `CTA_ST_ZERO);
    #50 chk(sense_valid[s], 1'b1);
    chk(sense_byte[s], exp);
    #50 chk(status_valid[s], 1'b1);
    chk(status_byte[s], CEDE);
  endtask
  task automatic xfer(input int a, input logic [7:0] ca, input logic [15:0] na, input int b,
                      input logic [7:0] cb, input logic [15:0] nb, input int w);
    int i, r, r0;
    logic [7:0] e;
    i = 0;
    r = 1 - w;
    r0 = rxc[r];
    cmd(a, ca, na, `CTA_ST_ZERO);
    #50 chk(attention[b], 1'b1);
    cmd(b, cb, nb, `CTA_ST_ZERO);
    do #50; while (status_valid !== 2'b11 && ++i < 300);
    chk(status_valid, 2'b11);
    chk({status_byte[0], status_byte[1]}, {CEDE, CEDE});
    e = (w ? 8'h80 : 8'h10) + 8'(txc[w] - 1);
    chk(16'(rxc[r] - r0), (na < nb) ? na : nb);
    chk(rxl[r], e);
  endtask
  task automatic rst(input logic [1:0] sy, input logic [1:0] se, input logic [1:0] ha);
    sys_reset_req = sy;
    sel_reset_req = se;
    halt_req = ha;
    #50 {sys_reset_req, sel_reset_req, halt_req} = 6'h00;
    #200;
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // sequence needs some 100 cycles
  initial
  begin
    #400us fail_count++;
    tally_and_finish;
  end
  initial
  begin
    {nrst, slow, cmd_valid, load_active, sys_reset_req, sel_reset_req, halt_req} = 12'h000;
    cmd_byte = 16'h0000;
    cmd_count = 32'h0000_0000;
    repeat (16) @(posedge sys_clk);
    #2 nrst = 1'b1;
    sense(1, `CTA_ST_ZERO);
    xfer(0, `CTA_OP_READ, 5, 1, `CTA_OP_WRITE, 3, 1);
    slow = 1'b1;
    xfer(0, `CTA_OP_WRITE, 4, 1, `CTA_OP_READ_BACK, 6, 0);
    cmd(0, `CTA_OP_READ, 2, `CTA_ST_ZERO);
    cmd(1, `CTA_OP_READ, 2, `CTA_ST_BUSY);
    cmd(1, `CTA_OP_WEOF, 1, CEDE);
    chk(status_byte[0], CEDE | `CTA_ST_UX);
    xfer(1, `CTA_OP_WRITE, 2, 0, `CTA_OP_READ, 2, 1);
    cmd(1, `CTA_OP_WEOF, 1, CEDE);
    cmd(0, `CTA_OP_READ, 2, CEDE | `CTA_ST_UX);
    cmd(1, `CTA_OP_WRITE, 3, `CTA_ST_ZERO);
    load_active[0] = 1'b1;
    cmd(0, `CTA_OP_READ, 3, `CTA_ST_ZERO);
    chk(status_byte[1], CEDE | `CTA_ST_UC);
    load_active[0] = 1'b0;
    rst(2'b00, 2'b01, 2'b00);
    chk(attention, 2'b00);
    chk(not_ready[0], 1'b1);
    sense(1, `CTA_SNS_INTV | `CTA_SNS_HALT);
    chk(not_ready[0], 1'b1);
    cmd(1, `CTA_OP_READ, 1, `CTA_ST_UC);
    cmd(0, 8'h03, 1, CEDE);
    cmd(0, 8'h07, 1, `CTA_ST_CE);
    #50 chk(attention[1], 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      rst(k ? 2'b10 : 2'b00, 2'b00, k ? 2'b00 : 2'b10);
      chk(attention, 2'b00);
      sense(0, k ? `CTA_SNS_INTV : (`CTA_SNS_INTV | `CTA_SNS_HALT));
      cmd(1, 8'h03, 1, CEDE);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
